/* File: inc/slrc_defines.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef SLRC_DEFINES_SVH
`define SLRC_DEFINES_SVH

`define SLRC_CLK_HZ 50000000
`define SLRC_TICK_US 250
`define SLRC_TICK_CYC ((`SLRC_CLK_HZ / 1000000) * `SLRC_TICK_US)

`define SLRC_OFS_CTRL 8'h00
`define SLRC_OFS_SETPT 8'h04
`define SLRC_OFS_ACCEL 8'h08
`define SLRC_OFS_DECEL 8'h0C
`define SLRC_OFS_EMERG 8'h10
`define SLRC_OFS_DISR 8'h14
`define SLRC_OFS_CEIL 8'h18
`define SLRC_OFS_NCEIL 8'h1C
`define SLRC_OFS_OVSPD 8'h20
`define SLRC_OFS_STILL 8'h24
`define SLRC_OFS_GAIN 8'h28
`define SLRC_OFS_INTT 8'h2C
`define SLRC_OFS_MIDT 8'h30
`define SLRC_OFS_FILT 8'h34
`define SLRC_OFS_FFR 8'h38
`define SLRC_OFS_STAT 8'h3C
`define SLRC_OFS_CMD 8'h40
`define SLRC_OFS_CUR 8'h44

`define SLRC_CTRL_DIR 0
`define SLRC_CTRL_BRAKE 1
`define SLRC_CTRL_STOPM 2
`define SLRC_CTRL_FAULTB 3
`define SLRC_CTRL_NCEIL_EN 4
`define SLRC_CTRL_CLRF 5

`define SLRC_ST_STILL 0
`define SLRC_ST_OVSPD 1
`define SLRC_ST_ESTOP 2
`define SLRC_ST_STAGE 3
`define SLRC_ST_BRAKE 4

`define SLRC_RST_CTRL 32'h0000_0001
`define SLRC_RST_RAMP 16'h000A
`define SLRC_RAMP_MAX 16'h7FFF
`define SLRC_RST_CEIL 16'h0BB8
`define SLRC_RST_OVSPD 16'h0E10
`define SLRC_RST_STILL 16'h0005
`define SLRC_RST_GAIN 16'h0100
`define SLRC_RST_INTT 16'h000A
`define SLRC_RST_MIDT 16'h0001
`define SLRC_RST_FILT 16'h0004
`define SLRC_RST_FFR 16'h0100
`define SLRC_FAULT_OVSPD 8'h08
`define SLRC_PEAK_ERR 16'h0BB8
`define SLRC_INPUT_ESTOP 8'h1B

`endif

/* File: inc/slrc_pkg.sv */
// Types shared by the speed loop and ramp control block
package slrc_pkg;
  typedef enum logic [1:0] {RAMP_NORMAL, RAMP_DISABLE, RAMP_EMERG} slrc_ramp_t;
  typedef struct packed {
    logic hw_enable;
    logic sw_enable;
    logic amp_fault;
    logic follow_err;
    logic bus_thresh;
    logic limit_sw;
    logic bus_estop;
    logic warn_follow;
    logic warn_resp;
    logic [7:0] input_function_select;
    logic input_active;
  } slrc_events_t;
endpackage : slrc_pkg

/* File: rtl/slrc_speed_loop.sv */
// Speed loop, setpoint ramp, overspeed and standstill logic with AXI4-Lite
//
// The register addresses and the AXI4-Lite register port were decided locally.
`timescale 1ns/10ps
`include "slrc_defines.svh"

module slrc_speed_loop #(
  parameter int TICK_CYC = `SLRC_TICK_CYC
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire slrc_pkg::slrc_events_t events,
  input wire logic signed [15:0] actual_speed,
  output logic signed [15:0] current_cmd,
  output logic stage_enable,
  output logic brake_engage,
  output logic [7:0] fault_code
);
  import slrc_pkg::*;

  // ==========================================================
  // Input synchronisers
  slrc_events_t ev_meta_reg, ev_reg;
  logic signed [15:0] spd_meta_reg, spd_reg;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ev_meta_reg <= '0;
      ev_reg <= '0;
      spd_meta_reg <= 16'sh0000;
      spd_reg <= 16'sh0000;
    end else begin
      ev_meta_reg <= events;
      ev_reg <= ev_meta_reg;
      spd_meta_reg <= actual_speed;
      spd_reg <= spd_meta_reg;
    end
  end

  // ==========================================================
  // Registers and AXI4-Lite slave
  logic [31:0] ctrl_reg;
  logic signed [15:0] setpt_reg;
  logic [15:0] accel_reg, decel_reg, emerg_reg, disr_reg;
  logic [15:0] ceil_reg, nceil_reg, ovspd_reg, still_reg;
  logic [15:0] gain_reg, intt_reg, midt_reg, filt_reg, ffr_reg;
  logic aw_reg, w_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [31:0] status_word;
  logic signed [15:0] cmd_reg;
  logic ovspd_flag_reg;
  logic clr_pulse;

  function automatic logic [15:0] clamp_time(input logic [15:0] v);
    if (v == 16'h0000) clamp_time = 16'h0001;
    else if (v > `SLRC_RAMP_MAX) clamp_time = `SLRC_RAMP_MAX;
    else clamp_time = v;
  endfunction : clamp_time

  wire do_write = aw_reg && w_reg && !s_axi_bvalid;
  assign clr_pulse = do_write && awaddr_reg == `SLRC_OFS_CTRL &&
                     wdata_reg[`SLRC_CTRL_CLRF];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      aw_reg <= 1'b0;
      w_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      s_axi_awready <= !aw_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
      end
      if (do_write) begin
        aw_reg <= 1'b0;
        w_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_reg <= `SLRC_OFS_FFR &&
                        awaddr_reg[1:0] == 2'h0) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Config writes; byte strobes are ignored, the 16-bit fields take the low half
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `SLRC_RST_CTRL;
      setpt_reg <= 16'sh0000;
      accel_reg <= `SLRC_RST_RAMP;
      decel_reg <= `SLRC_RST_RAMP;
      emerg_reg <= `SLRC_RST_RAMP;
      disr_reg <= `SLRC_RST_RAMP;
      ceil_reg <= `SLRC_RST_CEIL;
      nceil_reg <= `SLRC_RST_CEIL;
      ovspd_reg <= `SLRC_RST_OVSPD;
      still_reg <= `SLRC_RST_STILL;
      gain_reg <= `SLRC_RST_GAIN;
      intt_reg <= `SLRC_RST_INTT;
      midt_reg <= `SLRC_RST_MIDT;
      filt_reg <= `SLRC_RST_FILT;
      ffr_reg <= `SLRC_RST_FFR;
    end else if (do_write) begin
      unique case (awaddr_reg)
        `SLRC_OFS_CTRL: ctrl_reg <= {26'h0, 1'b0, wdata_reg[4:0]};
        `SLRC_OFS_SETPT: setpt_reg <= wdata_reg[15:0];
        `SLRC_OFS_ACCEL: accel_reg <= clamp_time(wdata_reg[15:0]);
        `SLRC_OFS_DECEL: decel_reg <= clamp_time(wdata_reg[15:0]);
        `SLRC_OFS_EMERG: emerg_reg <= clamp_time(wdata_reg[15:0]);
        `SLRC_OFS_DISR: disr_reg <= clamp_time(wdata_reg[15:0]);
        `SLRC_OFS_CEIL: ceil_reg <= wdata_reg[15:0];
        `SLRC_OFS_NCEIL: nceil_reg <= wdata_reg[15:0];
        `SLRC_OFS_OVSPD: ovspd_reg <= wdata_reg[15:0];
        `SLRC_OFS_STILL: still_reg <= wdata_reg[15:0];
        `SLRC_OFS_GAIN: gain_reg <= wdata_reg[15:0];
        `SLRC_OFS_INTT: intt_reg <= wdata_reg[15:0];
        `SLRC_OFS_MIDT: midt_reg <= wdata_reg[15:0];
        `SLRC_OFS_FILT: filt_reg <= wdata_reg[15:0];
        `SLRC_OFS_FFR: ffr_reg <= (wdata_reg[15:0] > `SLRC_RST_FFR) ?
                          `SLRC_RST_FFR : wdata_reg[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'h0;
        unique case (s_axi_araddr)
          `SLRC_OFS_CTRL: s_axi_rdata <= ctrl_reg;
          `SLRC_OFS_SETPT: s_axi_rdata <= {{16{setpt_reg[15]}}, setpt_reg};
          `SLRC_OFS_ACCEL: s_axi_rdata <= {16'h0, accel_reg};
          `SLRC_OFS_DECEL: s_axi_rdata <= {16'h0, decel_reg};
          `SLRC_OFS_EMERG: s_axi_rdata <= {16'h0, emerg_reg};
          `SLRC_OFS_DISR: s_axi_rdata <= {16'h0, disr_reg};
          `SLRC_OFS_CEIL: s_axi_rdata <= {16'h0, ceil_reg};
          `SLRC_OFS_NCEIL: s_axi_rdata <= {16'h0, nceil_reg};
          `SLRC_OFS_OVSPD: s_axi_rdata <= {16'h0, ovspd_reg};
          `SLRC_OFS_STILL: s_axi_rdata <= {16'h0, still_reg};
          `SLRC_OFS_GAIN: s_axi_rdata <= {16'h0, gain_reg};
          `SLRC_OFS_INTT: s_axi_rdata <= {16'h0, intt_reg};
          `SLRC_OFS_MIDT: s_axi_rdata <= {16'h0, midt_reg};
          `SLRC_OFS_FILT: s_axi_rdata <= {16'h0, filt_reg};
          `SLRC_OFS_FFR: s_axi_rdata <= {16'h0, ffr_reg};
          `SLRC_OFS_STAT: s_axi_rdata <= status_word;
          `SLRC_OFS_CMD: s_axi_rdata <= {{16{cmd_reg[15]}}, cmd_reg};
          `SLRC_OFS_CUR: s_axi_rdata <= {{16{current_cmd[15]}}, current_cmd};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // 250 us tick
  logic [15:0] tick_cnt_reg;
  logic tick;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= tick_cnt_reg == 16'(TICK_CYC - 1);
      tick_cnt_reg <= (tick_cnt_reg == 16'(TICK_CYC - 1)) ? 16'h0000 :
                      tick_cnt_reg + 16'h0001;
    end
  end

  // ==========================================================
  // Speed feedback filter and monitors
  logic signed [31:0] filt_acc_reg;
  logic signed [15:0] spd_filt;
  logic [15:0] spd_abs;
  logic still;
  assign spd_filt = filt_acc_reg[31:16];
  assign spd_abs = spd_filt[15] ? 16'(-spd_filt) : spd_filt;
  assign still = spd_abs < still_reg;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      filt_acc_reg <= 32'sh0000_0000;
    end else if (tick) begin
      // Alpha = 0.3 ms / (T + 0.3 ms), T in 0.1 ms units
      filt_acc_reg <= filt_acc_reg + ((($signed({spd_reg, 16'h0000}) -
        filt_acc_reg) / $signed(32'(filt_reg) + 32'd3)) *
        32'sd3);
    end
  end

  wire estop_in = (ev_reg.amp_fault && ctrl_reg[`SLRC_CTRL_FAULTB]) ||
    ev_reg.follow_err || ev_reg.bus_thresh || ev_reg.limit_sw ||
    ev_reg.bus_estop || ev_reg.warn_follow || ev_reg.warn_resp ||
    (ev_reg.input_active &&
     ev_reg.input_function_select == `SLRC_INPUT_ESTOP);
  wire enabled = ev_reg.hw_enable && ev_reg.sw_enable;
  wire active_stop = ctrl_reg[`SLRC_CTRL_BRAKE] ||
                     ctrl_reg[`SLRC_CTRL_STOPM];

  // Overspeed fault latch; a new overspeed wins over software clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ovspd_flag_reg <= 1'b0;
      fault_code <= 8'h00;
    end else begin
      if (spd_abs > ovspd_reg) begin
        ovspd_flag_reg <= 1'b1;
        fault_code <= `SLRC_FAULT_OVSPD;
      end else if (clr_pulse) begin
        ovspd_flag_reg <= 1'b0;
        fault_code <= 8'h00;
      end
    end
  end

  // ==========================================================
  // Ramp generator
  slrc_ramp_t ramp_sel;
  logic signed [15:0] target;
  logic [15:0] ramp_time;
  logic [15:0] lim_pos, lim_neg;
  logic [31:0] step_q;
  logic [15:0] step;
  logic signed [16:0] dir_sp;

  always_comb begin
    lim_pos = ceil_reg;
    lim_neg = ctrl_reg[`SLRC_CTRL_NCEIL_EN] ? nceil_reg : ceil_reg;
    dir_sp = ctrl_reg[`SLRC_CTRL_DIR] ? 17'(setpt_reg) :
             -17'(setpt_reg);
    if (dir_sp > $signed({1'b0, lim_pos})) target = lim_pos;
    else if (dir_sp < -$signed({1'b0, lim_neg})) target = -lim_neg;
    else target = dir_sp[15:0];
    // Priority: emergency, then disable, then normal
    if (estop_in || ovspd_flag_reg) begin
      ramp_sel = RAMP_EMERG;
      target = 16'sh0000;
    end else if (!enabled) begin
      ramp_sel = RAMP_DISABLE;
      target = 16'sh0000;
    end else begin
      ramp_sel = RAMP_NORMAL;
    end
    unique case (ramp_sel)
      RAMP_EMERG: ramp_time = emerg_reg;
      RAMP_DISABLE: ramp_time = disr_reg;
      RAMP_NORMAL: ramp_time = (target == 16'sh0000 ||
        (target[15] != cmd_reg[15] && cmd_reg != 16'sh0000) ||
        (target[15] ? target > cmd_reg : target < cmd_reg)) ?
        decel_reg : accel_reg;
    endcase
    // Ramp time in ms: 4 ticks per ms, round step up
    step_q = (32'(cmd_reg[15] ? lim_neg : lim_pos) + 32'(ramp_time) * 32'd4
              - 32'd1) / (32'(ramp_time) * 32'd4);
    step = (step_q == 32'd0) ? 16'h0001 : step_q[15:0];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd_reg <= 16'sh0000;
    end else if (tick) begin
      if (ramp_sel == RAMP_DISABLE && !active_stop) begin
        cmd_reg <= 16'sh0000;
      end else if (cmd_reg < target) begin
        cmd_reg <= (32'(target) - 32'(cmd_reg) > 32'(step)) ?
                   16'(cmd_reg + $signed(step)) : target;
      end else if (cmd_reg > target) begin
        cmd_reg <= (32'(cmd_reg) - 32'(target) > 32'(step)) ?
                   16'(cmd_reg - $signed(step)) : target;
      end
    end
  end

  // ==========================================================
  // Output stage and brake
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage_enable <= 1'b0;
      brake_engage <= 1'b1;
    end else if (tick) begin
      if (enabled && !ovspd_flag_reg) begin
        stage_enable <= 1'b1;
        brake_engage <= 1'b0;
      end else if (!enabled && !active_stop) begin
        stage_enable <= 1'b0;
        brake_engage <= ctrl_reg[`SLRC_CTRL_BRAKE];
      end else if (ovspd_flag_reg && !active_stop) begin
        stage_enable <= 1'b0;
      end else if (still) begin
        stage_enable <= 1'b0;
        brake_engage <= ctrl_reg[`SLRC_CTRL_BRAKE];
      end
    end
  end

  // ==========================================================
  // PI regulator with midband and feedforward ratio
  logic signed [31:0] integ_reg, mid_reg;
  logic signed [31:0] err, pterm, drive_in;
  logic signed [47:0] raw;
  always_comb begin
    err = 32'(cmd_reg) - 32'(spd_filt);
    // Feedforward ratio 256 = 1.0 is used only with integral on
    if (intt_reg != 16'h0000)
      drive_in = (32'(cmd_reg) * $signed(32'(ffr_reg))) / 32'sd256 -
                 32'(spd_filt);
    else
      drive_in = err;
    // Lead term: extra gain on changes, unity gain at steady state
    pterm = drive_in + ((drive_in - mid_reg) >>> 1);
    // Gain 256 = 1.0; 3000 error at gain 1 gives 32767
    raw = 48'(pterm) * $signed(48'(gain_reg)) * 48'sd32767 /
          $signed(48'sd256 * 48'(`SLRC_PEAK_ERR)) +
          48'(integ_reg);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      integ_reg <= 32'sh0000_0000;
      mid_reg <= 32'sh0000_0000;
      current_cmd <= 16'sh0000;
    end else if (tick) begin
      if (intt_reg == 16'h0000 || !stage_enable)
        integ_reg <= 32'sh0000_0000;
      else
        integ_reg <= integ_reg + err / $signed(32'(intt_reg) * 32'd4);
      // Damping: smoothed drive term for the lead, time in ms
      mid_reg <= mid_reg + (drive_in - mid_reg) /
                 $signed(32'(midt_reg) * 32'd4 + 32'd1);
      if (!stage_enable) current_cmd <= 16'sh0000;
      else if (raw > 48'sd32767) current_cmd <= 16'sh7FFF;
      else if (raw < -48'sd32767) current_cmd <= -16'sh7FFF;
      else current_cmd <= raw[15:0];
    end
  end

  assign status_word = {27'h0, brake_engage, stage_enable,
                        estop_in, ovspd_flag_reg, still};

  // ==========================================================
  // Assertions
  tick_period_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick |=> !tick [*8]) else $error("tick repeats too soon");
  ovspd_latch_a: assert property (@(posedge core_clk) disable iff (!nrst)
    spd_abs > ovspd_reg |=> fault_code == `SLRC_FAULT_OVSPD)
    else $error("overspeed not reported");
  emerg_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
    estop_in |-> ramp_sel == RAMP_EMERG)
    else $error("emergency ramp not chosen");
  no_overshoot_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && cmd_reg <= target && ramp_sel != RAMP_DISABLE |=>
    cmd_reg <= $past(target)) else $error("ramp overshoot");
  stage_still_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(stage_enable) && active_stop |-> $past(still))
    else $error("stage off while moving");
  coast_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && !enabled && !active_stop |=> !stage_enable && cmd_reg == 0)
    else $error("coast not immediate");
  brake_still_a: assert property (@(posedge core_clk) disable iff (!nrst)
    $rose(brake_engage) && active_stop |-> $past(still))
    else $error("brake while moving");
  integ_off_a: assert property (@(posedge core_clk) disable iff (!nrst)
    tick && intt_reg == 0 |=> integ_reg == 0)
    else $error("integral not off");
  ceil_a: assert property (@(posedge core_clk) disable iff (!nrst)
    target <= $signed({1'b0, lim_pos})) else $error("ceiling broken");
  cov_ovspd: cover property (@(posedge core_clk) $rose(ovspd_flag_reg));
  cov_estop: cover property (@(posedge core_clk) $rose(estop_in));
  cov_disable: cover property (@(posedge core_clk) $fell(stage_enable));
endmodule : slrc_speed_loop

/* File: verification/slrc_motor_model.sv */
// Motor and speed feedback model facing the speed loop
`timescale 1ns/10ps
module slrc_motor_model (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic signed [15:0] current_cmd,
  input wire logic stage_enable,
  input wire logic hold,
  input wire logic signed [15:0] set_speed,
  output logic signed [15:0] actual_speed
);
  // Forced speed, torque drift, or coasting once the stage is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      actual_speed <= 16'sh0000;
    end else if (hold) begin
      actual_speed <= set_speed;
    end else if (stage_enable) begin
      actual_speed <= actual_speed + (current_cmd >>> 12);
    end else begin
      actual_speed <= actual_speed - (actual_speed >>> 4);
    end
  end
endmodule : slrc_motor_model

/* File: verification/testbench.sv */
// Self-checking bench for the speed loop and ramp control block
`timescale 1ns/10ps
module testbench;
  import slrc_pkg::*;
  localparam int TK = 20;
  logic core_clk, nrst, awvalid, wvalid, bready, arvalid, rready, hold;
  logic awready, wready, bvalid, arready, rvalid, stage, brake;
  logic [7:0] awaddr, araddr, fcode;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  slrc_events_t ev;
  logic signed [15:0] speed, cur, setspd;
  int num_errors, check_count;
  logic [7:0] ra [10] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h20,
    8'h24, 8'h2C, 8'h38};
  logic [15:0] re [10] = '{16'h1, 16'hA, 16'hA, 16'hA, 16'hA, 16'hBB8,
    16'hE10, 16'h5, 16'hA, 16'h100};
  slrc_speed_loop #(.TICK_CYC(TK)) i_slrc_speed_loop (.core_clk(core_clk),
    .nrst(nrst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .events(ev), .actual_speed(speed), .current_cmd(cur),
    .stage_enable(stage), .brake_engage(brake), .fault_code(fcode));
  slrc_motor_model i_slrc_motor_model (.core_clk(core_clk), .nrst(nrst),
    .current_cmd(cur), .stage_enable(stage), .hold(hold),
    .set_speed(setspd), .actual_speed(speed));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // ==========================================================
  // Checks and bus tasks
  task automatic check_word(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : check_word
  task automatic check_bit(input string nm, input logic e, input logic g);
    check_word(nm, {31'h0, e}, {31'h0, g});
  endtask : check_bit
  task automatic tick(input int n);
    repeat (n * TK) @(posedge core_clk);
  endtask : tick
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 100);
    if (n >= 100) num_errors++;
    bready <= 1'b0;
    @(posedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
    output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 100);
    if (n >= 100) num_errors++;
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge core_clk);
  endtask : rd
  task automatic reg16(input logic [7:0] a, input logic [15:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    check_word($sformatf("reg %h", a), {16'h0, e}, {16'h0, d[15:0]});
  endtask : reg16
  task automatic stat(input int b, input logic e);
    logic [31:0] d;
    logic [1:0] r;
    rd(8'h3C, d, r);
    check_bit("status", e, d[b]);
  endtask : stat
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    test_done();
  end
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] t;
    {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ev} = '0;
    hold = 1'b1;
    setspd = 16'sh0000;
    num_errors = 0;
    check_count = 0;
    void'($urandom(47));
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    check_bit("brake at reset", 1'b1, brake);
    foreach (ra[i]) reg16(ra[i], re[i]);
    rd(8'h80, d, r);
    check_word("unmapped", 32'h2, {30'h0, r});
    for (int a = 8'h08; a <= 8'h14; a += 4) wr(a[7:0], 32'h1);
    ev.hw_enable <= 1'b1;
    ev.sw_enable <= 1'b1;
    tick(2);
    stat(0, 1'b1);
    wr(8'h04, 32'd3000);
    tick(2);
    rd(8'h40, d, r);
    check_bit("ramp partial", 1'b1, d[15:0] < 16'd3000);
    tick(4);
    reg16(8'h40, 16'd3000);
    check_word("peak", 32'h7FFF, {16'h0, cur});
    wr(8'h04, 32'd0);
    tick(2);
    rd(8'h40, d, r);
    check_bit("decel partial", 1'b1, d[15:0] != 16'd0);
    tick(3);
    reg16(8'h40, 16'd0);
    for (int i = 0; i < 5; i++) begin
      t = (i == 4) ? 16'd0 : 16'($urandom_range(6000) - 3000);
      wr(8'h04, {{16{t[15]}}, t});
      tick(10);
      reg16(8'h40, t);
    end
    setspd <= 16'sd100;
    ev.hw_enable <= 1'b0;
    tick(2);
    stat(0, 1'b0);
    wr(8'h00, 32'h0);
    ev.hw_enable <= 1'b1;
    wr(8'h04, 32'd3000);
    tick(8);
    check_word("reverse", 32'h8001, {16'h0, cur});
    ev.hw_enable <= 1'b0;
    tick(2);
    check_bit("coast", 1'b0, stage);
    wr(8'h00, 32'h3);
    ev.hw_enable <= 1'b1;
    tick(8);
    ev.hw_enable <= 1'b0;
    tick(3);
    check_bit("stage held", 1'b1, stage);
    check_bit("brake held", 1'b0, brake);
    tick(3);
    reg16(8'h40, 16'd0);
    setspd <= 16'sd0;
    tick(8);
    check_bit("stage off", 1'b0, stage);
    check_bit("brake on", 1'b1, brake);
    wr(8'h00, 32'h9);
    ev.hw_enable <= 1'b1;
    tick(8);
    wr(8'h0C, 32'd1000);
    ev.warn_follow <= 1'b1;
    tick(6);
    reg16(8'h40, 16'd0);
    ev.warn_follow <= 1'b0;
    for (int i = 9; i < 16; i++) begin
      ev[i] <= 1'b1;
      tick(2);
      stat(2, 1'b1);
      ev[i] <= 1'b0;
      tick(2);
    end
    ev.input_function_select <= 8'h1B;
    ev.input_active <= 1'b1;
    tick(2);
    stat(2, 1'b1);
    ev.input_active <= 1'b0;
    setspd <= 16'sd3600;
    tick(2);
    check_word("no fault", 32'h0, {24'h0, fcode});
    setspd <= 16'sd3700;
    tick(10);
    check_word("fault", 32'h8, {24'h0, fcode});
    stat(1, 1'b1);
    check_bit("fault stage", 1'b0, stage);
    setspd <= 16'sd0;
    tick(2);
    wr(8'h00, 32'h21);
    tick(1);
    check_word("cleared", 32'h0, {24'h0, fcode});
    test_done();
  end
endmodule : testbench
